// ==== index_home_pin_mux.sv ====
// index/home pin multiplexer for two port c pins
`timescale 1ns/1ns
`default_nettype none
module index_home_pin_mux
    import pin_mux_pkg::*;
#(
    parameter bit HAS_DECODER = 1'b1,
    parameter int PULLUP_W = PULLUP_REG_WIDTH
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic index_pad_i,
    input wire logic home_pad_i,
    input wire pin_select_type system_pin_select_reg_i,
    input wire logic [PULLUP_W-1:0] port_c_pullup_reg_i,
    input wire gpio_ctl_type port_c_line_two_ctl_i,
    input wire gpio_ctl_type port_c_line_three_ctl_i,
    input wire spi_ctl_type spi_ctl_i,
    output logic index_pad_o,
    output logic index_pad_oe_o,
    output logic home_pad_o,
    output logic home_pad_oe_o,
    output logic index_pullup_en_o,
    output logic home_pullup_en_o,
    output logic decoder_index_in_o,
    output logic decoder_home_in_o,
    output logic timer_b_channel_two_o,
    output logic timer_b_channel_three_o,
    output logic spi_one_master_in_o,
    output logic spi_one_slave_select_n_o,
    output logic spi_one_master_out_o,
    output logic spi_mode_fault_o,
    output logic port_c_line_two_o,
    output logic port_c_line_three_o,
    output pin_fn_type index_fn_o,
    output pin_fn_type home_fn_o
);
    // gpio wins over the alternate bit; otherwise the decoder keeps the pin once it is configured
    function automatic pin_fn_type select_fn(
        input logic gpio_en,
        input logic alt,
        input logic configured
    );
        pin_fn_type fn;
        if (gpio_en) begin
            fn = FN_GPIO;
        end else if (alt) begin
            fn = FN_SPI;
        end else if (configured) begin
            fn = FN_DECODER;
        end else begin
            fn = FN_NONE;
        end
        return fn;
    endfunction

    localparam pin_fn_type HOME_RESET_FN = HAS_DECODER ? FN_DECODER : FN_NONE;
    localparam logic HOME_CONF_RESET = HAS_DECODER ? 1'h1 : 1'h0;
    localparam logic CONFIGURED = 1'h1;

    logic home_configured;
    pin_fn_type next_index_fn;
    pin_fn_type next_home_fn;
    wire logic home_touched;
    wire logic next_home_configured;
    wire logic master;
    wire logic ss_n_now;
    wire logic miso_drive;
    wire logic miso_bit;
    wire logic mosi_bit;
    wire logic next_index_pad;
    wire logic next_index_oe;
    wire logic next_home_pad;
    wire logic next_home_oe;
    wire logic next_decoder_index;
    wire logic next_decoder_home;
    wire logic next_line_two;
    wire logic next_line_three;
    wire logic next_master_in;
    wire logic next_fault;

    assign master = spi_ctl_i.master_mode;
    // reduced variant: home pin stays unassigned until software picks one
    assign home_touched = port_c_line_three_ctl_i.gpio_enable
        | system_pin_select_reg_i.home_pin_alt_select;
    assign next_home_configured = home_configured | home_touched;
    assign next_index_fn = select_fn(port_c_line_two_ctl_i.gpio_enable,
        system_pin_select_reg_i.index_pin_alt_select, CONFIGURED);
    assign next_home_fn = select_fn(port_c_line_three_ctl_i.gpio_enable,
        system_pin_select_reg_i.home_pin_alt_select,
        next_home_configured);

    // slave select comes from the home pin only in its spi function
    assign ss_n_now = (home_fn_o == FN_SPI) ? home_pad_i : SELECT_IDLE_N;
    // slave drives miso only while selected, master never
    assign miso_drive = ~master & ~ss_n_now;
    // master in is read from the pad only as master
    assign next_master_in = (index_fn_o == FN_SPI) & master
        ? index_pad_i : PIN_IDLE;
    // master sees a low select as another master on the bus
    assign next_fault = master & (home_fn_o == FN_SPI) & ~home_pad_i;

    bit_launcher u_miso_launch (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .sclk_i(spi_ctl_i.sclk),
        .clk_idle_high_i(spi_ctl_i.clk_idle_high),
        .clk_phase_i(spi_ctl_i.clk_phase),
        .load_i(ss_n_now),
        .bit_i(spi_ctl_i.slave_out_bit),
        .bit_o(miso_bit)
    );

    bit_launcher u_mosi_launch (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .sclk_i(spi_ctl_i.sclk),
        .clk_idle_high_i(spi_ctl_i.clk_idle_high),
        .clk_phase_i(spi_ctl_i.clk_phase),
        .load_i(spi_ctl_i.transfer_start),
        .bit_i(spi_ctl_i.master_out_bit),
        .bit_o(mosi_bit)
    );

    pin_cell u_index_cell (
        .fn_i(index_fn_o),
        .gpio_i(port_c_line_two_ctl_i),
        .spi_drive_i(miso_drive),
        .spi_bit_i(miso_bit),
        .pad_i(index_pad_i),
        .pad_out_o(next_index_pad),
        .pad_oe_o(next_index_oe),
        .decoder_view_o(next_decoder_index),
        .gpio_view_o(next_line_two)
    );

    // slave select is input only, so the home pin never drives in spi
    pin_cell u_home_cell (
        .fn_i(home_fn_o),
        .gpio_i(port_c_line_three_ctl_i),
        .spi_drive_i(DRIVE_OFF),
        .spi_bit_i(BIT_RESET),
        .pad_i(home_pad_i),
        .pad_out_o(next_home_pad),
        .pad_oe_o(next_home_oe),
        .decoder_view_o(next_decoder_home),
        .gpio_view_o(next_line_three)
    );

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            index_fn_o <= FN_DECODER;
            home_fn_o <= HOME_RESET_FN;
            home_configured <= HOME_CONF_RESET;
        end else if (clk_en_i) begin
            index_fn_o <= next_index_fn;
            home_fn_o <= next_home_fn;
            home_configured <= next_home_configured;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            index_pad_o <= BIT_RESET;
            index_pad_oe_o <= DRIVE_OFF;
            home_pad_o <= BIT_RESET;
            home_pad_oe_o <= DRIVE_OFF;
        end else if (clk_en_i) begin
            index_pad_o <= next_index_pad;
            index_pad_oe_o <= next_index_oe;
            home_pad_o <= next_home_pad;
            home_pad_oe_o <= next_home_oe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            index_pullup_en_o <= PULLUP_RESET;
            home_pullup_en_o <= PULLUP_RESET;
        end else if (clk_en_i) begin
            index_pullup_en_o <= port_c_pullup_reg_i[INDEX_PULLUP_BIT];
            home_pullup_en_o <= port_c_pullup_reg_i[HOME_PULLUP_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            decoder_index_in_o <= PIN_IDLE;
            decoder_home_in_o <= PIN_IDLE;
            timer_b_channel_two_o <= PIN_IDLE;
            timer_b_channel_three_o <= PIN_IDLE;
            port_c_line_two_o <= PIN_IDLE;
            port_c_line_three_o <= PIN_IDLE;
        end else if (clk_en_i) begin
            decoder_index_in_o <= next_decoder_index;
            decoder_home_in_o <= next_decoder_home;
            timer_b_channel_two_o <= next_decoder_index;
            timer_b_channel_three_o <= next_decoder_home;
            port_c_line_two_o <= next_line_two;
            port_c_line_three_o <= next_line_three;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            spi_one_master_in_o <= PIN_IDLE;
            spi_one_slave_select_n_o <= SELECT_IDLE_N;
            spi_one_master_out_o <= BIT_RESET;
            spi_mode_fault_o <= DRIVE_OFF;
        end else if (clk_en_i) begin
            spi_one_master_in_o <= next_master_in;
            spi_one_slave_select_n_o <= ss_n_now;
            spi_one_master_out_o <= mosi_bit;
            spi_mode_fault_o <= next_fault;
        end
    end

    sequence s_spi_slave_selected;
        clk_en_i && index_fn_o == FN_SPI && !master && !ss_n_now;
    endsequence

    a_miso_master_input: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && index_fn_o == FN_SPI && master
        |=> !index_pad_oe_o)
        else $error("miso driven while master");
    a_miso_slave_drive: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        s_spi_slave_selected
        |=> index_pad_oe_o && index_pad_o == $past(miso_bit))
        else $error("selected slave does not drive miso");
    a_miso_release: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && index_fn_o == FN_SPI && ss_n_now
        |=> !index_pad_oe_o)
        else $error("unselected slave holds miso");
    a_index_pin_alt_select_route: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && !port_c_line_two_ctl_i.gpio_enable
        && system_pin_select_reg_i.index_pin_alt_select
        |=> index_fn_o == FN_SPI)
        else $error("index_pin_alt_select bit ignored");
    a_home_pin_alt_select_route: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && !port_c_line_three_ctl_i.gpio_enable
        && system_pin_select_reg_i.home_pin_alt_select
        |=> home_fn_o == FN_SPI ##1 (!$past(clk_en_i)
        || spi_one_slave_select_n_o == $past(home_pad_i)))
        else $error("home_pin_alt_select bit ignored");
    a_index_reset_fn: assert property (@(posedge clk_i)
        $rose(reset_n_i) |-> index_fn_o == FN_DECODER)
        else $error("index pin not decoder after reset");
    a_home_reset_fn: assert property (@(posedge clk_i)
        $rose(reset_n_i) |-> home_fn_o == HOME_RESET_FN)
        else $error("home pin wrong after reset");
    a_pullup_index: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && !port_c_pullup_reg_i[INDEX_PULLUP_BIT]
        |=> !index_pullup_en_o)
        else $error("index pull-up not disabled");
    a_pullup_home: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && !port_c_pullup_reg_i[HOME_PULLUP_BIT]
        |=> !home_pullup_en_o)
        else $error("home pull-up not disabled");
    a_master_fault: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && master && home_fn_o == FN_SPI && !home_pad_i
        |=> spi_mode_fault_o)
        else $error("master misses select arbitration");
    a_gpio_dir: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && index_fn_o == FN_GPIO
        |=> index_pad_oe_o == $past(port_c_line_two_ctl_i.gpio_dir_out))
        else $error("gpio direction not followed");
    a_decoder_keep: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        clk_en_i && !port_c_line_two_ctl_i.gpio_enable
        && !system_pin_select_reg_i.index_pin_alt_select
        |=> index_fn_o == FN_DECODER)
        else $error("index pin left decoder function");
endmodule
`default_nettype wire

// ==== pin_mux_pkg.sv ====
// shared constants and types for the index/home pin multiplexer
package pin_mux_pkg;
    typedef enum logic [1:0] {
        FN_NONE = 2'b00,
        FN_DECODER = 2'b01,
        FN_SPI = 2'b10,
        FN_GPIO = 2'b11
    } pin_fn_type;

    typedef struct packed {
        logic index_pin_alt_select;
        logic home_pin_alt_select;
    } pin_select_type;

    typedef struct packed {
        logic gpio_enable;
        logic gpio_dir_out;
        logic gpio_data;
    } gpio_ctl_type;

    typedef struct packed {
        logic master_mode;
        logic clk_idle_high;
        logic clk_phase;
        logic sclk;
        logic slave_out_bit;
        logic master_out_bit;
        logic transfer_start;
    } spi_ctl_type;

    localparam int PULLUP_REG_WIDTH = 16;
    localparam int INDEX_PULLUP_BIT = 2;
    localparam int HOME_PULLUP_BIT = 3;
    localparam logic PIN_IDLE = 1'h1;
    localparam logic PULLUP_RESET = 1'h1;
    localparam logic SELECT_IDLE_N = 1'h1;
    localparam logic BIT_RESET = 1'h0;
    localparam logic SCLK_RESET = 1'h0;
    localparam logic DRIVE_OFF = 1'h0;
endpackage

// ==== bit_launcher.sv ====
// serial bit launcher: changes its bit only on the launch edge of sclk or while load is high
`timescale 1ns/1ns
`default_nettype none
module bit_launcher
    import pin_mux_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic sclk_i,
    input wire logic clk_idle_high_i,
    input wire logic clk_phase_i,
    input wire logic load_i,
    input wire logic bit_i,
    output logic bit_o
);
    logic sclk_prev;
    wire logic sclk_rise;
    wire logic sclk_fall;
    wire logic sample_on_rise;
    wire logic launch_edge;
    wire logic sample_edge;

    assign sclk_rise = sclk_i & ~sclk_prev;
    assign sclk_fall = ~sclk_i & sclk_prev;
    assign sample_on_rise = ~(clk_idle_high_i ^ clk_phase_i);
    // launch half a period ahead of the sampling edge
    assign launch_edge = sample_on_rise ? sclk_fall : sclk_rise;
    assign sample_edge = sample_on_rise ? sclk_rise : sclk_fall;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            // track the pin in reset so an idle-high clock gives no false edge
            sclk_prev <= sclk_i;
            bit_o <= BIT_RESET;
        end else if (clk_en_i) begin
            sclk_prev <= sclk_i;
            if (launch_edge || load_i) begin
                bit_o <= bit_i;
            end
        end
    end

    sequence s_sample_only;
        clk_en_i && sample_edge && !load_i;
    endsequence

    a_launch_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_sample_only |=> bit_o == $past(bit_o))
        else $error("bit changed on the sampling edge");
    a_launch_take: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_en_i && (launch_edge || load_i) |=> bit_o == $past(bit_i))
        else $error("bit not taken on the launch edge");
endmodule
`default_nettype wire

// ==== pin_cell.sv ====
// pad driver selection for one multiplexed pin
`timescale 1ns/1ns
`default_nettype none
module pin_cell
    import pin_mux_pkg::*;
(
    input wire pin_fn_type fn_i,
    input wire gpio_ctl_type gpio_i,
    input wire logic spi_drive_i,
    input wire logic spi_bit_i,
    input wire logic pad_i,
    output logic pad_out_o,
    output logic pad_oe_o,
    output logic decoder_view_o,
    output logic gpio_view_o
);
    wire logic is_gpio;
    wire logic is_spi;

    assign is_gpio = (fn_i == FN_GPIO);
    assign is_spi = (fn_i == FN_SPI);
    // gpio direction is per pin
    assign pad_oe_o = is_gpio ? gpio_i.gpio_dir_out : (is_spi & spi_drive_i);
    assign pad_out_o = is_gpio ? gpio_i.gpio_data : spi_bit_i;
    // the decoder input rests at the idle level unless selected; the gpio view always follows the pad
    assign decoder_view_o = (fn_i == FN_DECODER) ? pad_i : PIN_IDLE;
    assign gpio_view_o = pad_i;
endmodule
`default_nettype wire

// ==== spi_peer_model.sv ====
// external spi master and encoder driving the two shared pads
`timescale 1ns/1ns
`default_nettype none
module spi_peer_model (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic idx_drive_i,
    input wire logic idx_level_i,
    input wire logic select_n_i,
    input wire logic index_pullup_en_i,
    input wire logic index_out_i,
    input wire logic index_oe_i,
    input wire logic home_out_i,
    input wire logic home_oe_i,
    output logic index_pad_o,
    output logic home_pad_o,
    output logic miso_seen_o = 1'h0
);
    logic sclk_q = 1'h0;
    logic churn = 1'h0;
    logic released;
    // undriven line without pull-up changes every cycle
    assign released = index_pullup_en_i ? 1'h1 : churn;
    assign index_pad_o = index_oe_i ? index_out_i :
        (idx_drive_i ? idx_level_i : released);
    // the master drives its select line whenever the home pad is not output enabled
    assign home_pad_o = home_oe_i ? home_out_i : select_n_i;
    always_ff @(posedge clk_i) begin
        churn <= ~churn;
        sclk_q <= sclk_i;
        // master samples slave data on the rising sclk edge
        if (sclk_i && !sclk_q) begin
            miso_seen_o <= index_pad_o;
        end
    end
endmodule
`default_nettype wire

// ==== index_home_pin_mux_bench.sv ====
// self-checking bench for the index/home pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module index_home_pin_mux_bench;
    import pin_mux_pkg::*;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic run = 1'h1;
    pin_select_type sel = '0;
    logic [15:0] pur = 16'hffff;
    gpio_ctl_type line_two = '0;
    gpio_ctl_type line_three = '0;
    spi_ctl_type spi = '0;
    logic idx_drive = 1'h0;
    logic idx_level = 1'h1;
    logic select_n = 1'h1;
    logic idx_pad, hom_pad, miso_seen, idx_out, idx_oe, hom_out, hom_oe;
    logic idx_pu, hom_pu, dec_idx, dec_hom, tmr2, tmr3, m_in, ss_n;
    logic m_out, fault, pc2, pc3;
    pin_fn_type idx_fn, hom_fn;
    pin_fn_type hom_fn_r;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    initial begin
        forever #4 clk = ~clk;
    end

    index_home_pin_mux index_home_pin_mux_inst (
        .clk_i(clk), .reset_n_i(reset_n), .clk_en_i(run),
        .index_pad_i(idx_pad), .home_pad_i(hom_pad),
        .system_pin_select_reg_i(sel), .port_c_pullup_reg_i(pur),
        .port_c_line_two_ctl_i(line_two),
        .port_c_line_three_ctl_i(line_three), .spi_ctl_i(spi),
        .index_pad_o(idx_out), .index_pad_oe_o(idx_oe),
        .home_pad_o(hom_out), .home_pad_oe_o(hom_oe),
        .index_pullup_en_o(idx_pu), .home_pullup_en_o(hom_pu),
        .decoder_index_in_o(dec_idx), .decoder_home_in_o(dec_hom),
        .timer_b_channel_two_o(tmr2), .timer_b_channel_three_o(tmr3),
        .spi_one_master_in_o(m_in), .spi_one_slave_select_n_o(ss_n),
        .spi_one_master_out_o(m_out), .spi_mode_fault_o(fault),
        .port_c_line_two_o(pc2), .port_c_line_three_o(pc3),
        .index_fn_o(idx_fn), .home_fn_o(hom_fn)
    );

    // reduced variant: home pin has no function until software picks one
    index_home_pin_mux #(.HAS_DECODER(1'h0)) index_home_pin_mux_reduced_inst (
        .clk_i(clk), .reset_n_i(reset_n), .clk_en_i(run),
        .index_pad_i(idx_pad), .home_pad_i(hom_pad),
        .system_pin_select_reg_i(sel), .port_c_pullup_reg_i(pur),
        .port_c_line_two_ctl_i(line_two),
        .port_c_line_three_ctl_i(line_three), .spi_ctl_i(spi),
        .index_pad_o(), .index_pad_oe_o(), .home_pad_o(), .home_pad_oe_o(),
        .index_pullup_en_o(), .home_pullup_en_o(),
        .decoder_index_in_o(), .decoder_home_in_o(),
        .timer_b_channel_two_o(), .timer_b_channel_three_o(),
        .spi_one_master_in_o(), .spi_one_slave_select_n_o(),
        .spi_one_master_out_o(), .spi_mode_fault_o(),
        .port_c_line_two_o(), .port_c_line_three_o(),
        .index_fn_o(), .home_fn_o(hom_fn_r)
    );

    spi_peer_model spi_peer_model_inst (
        .clk_i(clk), .sclk_i(spi.sclk), .idx_drive_i(idx_drive),
        .idx_level_i(idx_level), .select_n_i(select_n),
        .index_pullup_en_i(idx_pu), .index_out_i(idx_out),
        .index_oe_i(idx_oe), .home_out_i(hom_out), .home_oe_i(hom_oe),
        .index_pad_o(idx_pad), .home_pad_o(hom_pad),
        .miso_seen_o(miso_seen)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic test_reset();
        check(idx_fn, FN_DECODER);
        check(hom_fn, FN_DECODER);
        check(idx_pu, 1'h1);
        check(hom_pu, 1'h1);
        check(idx_oe, 1'h0);
        check(ss_n, 1'h1);
        check(hom_fn_r, FN_NONE);
    endtask

    task automatic test_pullup();
        @(posedge clk);
        pur <= 16'hfffb;
        settle(2);
        check(idx_pu, 1'h0);
        check(hom_pu, 1'h1);
        @(posedge clk);
        pur <= 16'hfff7;
        settle(2);
        check(idx_pu, 1'h1);
        check(hom_pu, 1'h0);
        @(posedge clk);
        pur <= 16'hffff;
    endtask

    task automatic test_decoder();
        @(posedge clk);
        idx_drive <= 1'h1;
        idx_level <= 1'h0;
        select_n <= 1'h0;
        settle(3);
        check(dec_idx, 1'h0);
        check(tmr2, 1'h0);
        check(m_in, 1'h1);
        check(dec_hom, 1'h0);
        check(tmr3, 1'h0);
        check(ss_n, 1'h1);
        check(hom_fn_r, FN_NONE);
        @(posedge clk);
        idx_drive <= 1'h0;
        select_n <= 1'h1;
    endtask

    task automatic test_slave();
        @(posedge clk);
        sel <= 2'h3;
        spi.slave_out_bit <= 1'h1;
        settle(3);
        check(idx_fn, FN_SPI);
        check(hom_fn, FN_SPI);
        check(idx_oe, 1'h0);
        @(posedge clk);
        select_n <= 1'h0;
        settle(3);
        check(ss_n, 1'h0);
        check(idx_oe, 1'h1);
        check(idx_out, 1'h1);
        @(posedge clk);
        spi.slave_out_bit <= 1'h0;
        spi.sclk <= 1'h1;
        settle(4);
        check(idx_out, 1'h1);
        check(miso_seen, 1'h1);
        @(posedge clk);
        spi.sclk <= 1'h0;
        settle(4);
        check(idx_out, 1'h0);
        @(posedge clk);
        spi.sclk <= 1'h1;
        settle(4);
        check(miso_seen, 1'h0);
        @(posedge clk);
        spi.sclk <= 1'h0;
        select_n <= 1'h1;
        settle(3);
        check(idx_oe, 1'h0);
        check(idx_pad, 1'h1);
    endtask

    task automatic test_master();
        @(posedge clk);
        spi.master_mode <= 1'h1;
        idx_drive <= 1'h1;
        idx_level <= 1'h0;
        spi.master_out_bit <= 1'h1;
        spi.transfer_start <= 1'h1;
        @(posedge clk);
        spi.transfer_start <= 1'h0;
        settle(3);
        check(idx_oe, 1'h0);
        check(m_in, 1'h0);
        check(fault, 1'h0);
        check(m_out, 1'h1);
        @(posedge clk);
        select_n <= 1'h0;
        spi.master_out_bit <= 1'h0;
        spi.sclk <= 1'h1;
        settle(3);
        check(fault, 1'h1);
        check(m_out, 1'h1);
        @(posedge clk);
        select_n <= 1'h1;
        spi.sclk <= 1'h0;
        settle(3);
        check(fault, 1'h0);
        check(m_out, 1'h0);
    endtask

    task automatic test_gpio();
        @(posedge clk);
        line_two <= 3'h7;
        line_three <= 3'h6;
        settle(3);
        check(idx_fn, FN_GPIO);
        check(hom_fn, FN_GPIO);
        check({idx_oe, idx_out, hom_oe, hom_out}, 4'hE);
        @(posedge clk);
        line_two <= 3'h4;
        line_three <= 3'h4;
        settle(3);
        check({idx_oe, hom_oe, pc2, pc3}, 4'h1);
        @(posedge clk);
        line_two <= 3'h0;
        line_three <= 3'h0;
        sel <= 2'h0;
        idx_drive <= 1'h0;
        settle(3);
        check({idx_fn, hom_fn}, 4'h5);
        check(hom_fn_r, FN_DECODER);
    endtask

    task automatic test_freeze();
        @(posedge clk);
        run <= 1'h0;
        sel <= 2'h2;
        pur <= 16'hfffb;
        settle(3);
        check({idx_fn, hom_fn}, 4'h5);
        check(idx_pu, 1'h1);
        @(posedge clk);
        run <= 1'h1;
        settle(2);
        check(idx_fn, FN_SPI);
        check(idx_pu, 1'h0);
        @(posedge clk);
        sel <= 2'h0;
        pur <= 16'hffff;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        settle(15);
        test_reset();
        @(posedge clk);
        reset_n <= 1'h1;
        settle(2);
        test_pullup();
        test_decoder();
        test_slave();
        test_master();
        test_gpio();
        test_freeze();
        report_and_stop();
    end
endmodule
`default_nettype wire
